// ==== intr_cfg_regs.svh ====
// register offsets, field positions, reset values and codes of the
// interrupt priority configuration block
// assumes byte addresses on an 8-bit wishbone address, one word per register
`ifndef INTR_CFG_REGS_SVH
`define INTR_CFG_REGS_SVH

`define ADR_MODE 8'h00
`define ADR_CPUPRI 8'h04
`define ADR_ENABLE 8'h08
`define ADR_SENSE_HI 8'h0C
`define ADR_SENSE_LO 8'h10
`define ADR_PENDING 8'h14
`define ADR_PRIO_BASE 8'h40
`define ADR_PRIO_MASK 8'hC0

`define MODE_SEL_LSB 4
`define NMI_EDGE_BIT 3
`define CPU_PCE_BIT 7
`define XFER_PRI_LSB 4
`define AUTO_PRI_BIT 3
`define CPU_PRI_LSB 0
`define VD_ENABLE_BIT 14
`define VD_SENSE_LSB 12

`define MODE_ZERO 2'h0
`define MODE_TWO 2'h2
`define PRIO_RESET 3'h7
`define SENSE_LOW 2'h0
`define SENSE_FALL 2'h1
`define SENSE_RISE 2'h2
`define SENSE_BOTH 2'h3

`endif

// ==== intr_cfg_pkg.sv ====
// types shared by the interrupt priority configuration block
// assumes intr_cfg_regs.svh holds the numbers
`default_nettype none
package intr_cfg_pkg;

    localparam int NSRC = 64;  // four fields in each of sixteen priority registers
    localparam int NEXT = 13;  // external inputs 11..0 plus the voltage detect input
    localparam int NSYNC = 14; // external inputs plus the nonmaskable pin

    // classic wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
    } wb_req_t;

    // wishbone answer
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;

    // current processor mask: flag of the condition register and three-bit mask
    typedef struct packed {
        logic single_mask_flag;
        logic [2:0] three_bit_interrupt_mask;
    } cpu_mask_t;

    // request presented to the processor
    typedef struct packed {
        logic req;
        logic [5:0] src;
        logic [2:0] lvl;
    } int_req_t;

    // all state of the block
    typedef struct packed {
        logic [NSYNC-1:0] sync1;
        logic [NSYNC-1:0] sync2;
        logic [NSYNC-1:0] sync3;
        logic [NSYNC-1:0] filt;
        logic [1:0] mode;
        logic nmi_edge;
        logic cpu_pce;
        logic [2:0] xfer_pri;
        logic auto_pri;
        logic [2:0] cpu_pri;
        logic [NEXT-1:0] enable;
        logic [NEXT-1:0][1:0] sense;
        logic [NEXT-1:0] pending;
        logic [NEXT-1:0] seen;
        logic [NSRC-1:0][2:0] prio;
        logic ack;
        logic [31:0] rdata;
        logic nmi_req;
        logic [NEXT-1:0] ext_req;
        int_req_t intr;
        logic cpu_wins;
    } state_t;

endpackage

`default_nettype wire

// ==== intr_cfg.sv ====
// interrupt priority configuration: mode, edge, priority and sense
// registers behind a classic wishbone slave, with pin sensing and arbitration
// assumes one clock, pins asynchronous to it, the processor supplies its mask
//
// Function
// - mode field: 00 mode 0, flag gates
// - mode 10 gates by three-bit mask, fields
// - nonmaskable edge: 0 falling, 1 rising
// - mode register reserved bits read zero
// - priority enable 0: processor always lowest
// - transfer controller level field, 0 to 7
// - auto enable copies processor mask into field
// - auto enable blocks software processor priority writes
// - auto off: field changes only by software
// - enabled: rank processor against transfer controller
// - four three-bit level fields per register
// - bits 15,11,7,3 zero; fields reset seven
// - requests pass only when enabled; reset off
// - input 14 driven by voltage detector
// - enable register reserved bits read zero
// - rise and fall sense bits per input
// - sense change may set pending flag
// - sense codes: low, fall, rise, both
// - pending sets on event; read-one-write-zero clears
//
// Our own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "intr_cfg_regs.svh"

module intr_cfg (
    input wire logic clk_in, // 100 MHz system clock
    input wire logic rst_b_in, // asynchronous reset, active low
    input wire logic ce_in, // clock enable, freezes all state when low
    input wire intr_cfg_pkg::wb_req_t wb_in, // wishbone request
    output intr_cfg_pkg::wb_rsp_t wb_out, // wishbone answer
    input wire logic [11:0] irq_pin_b_in, // external request pins 11..0
    input wire logic nmi_pin_in, // nonmaskable request pin
    input wire logic volt_detect_b_in, // voltage detector request, input 14
    input wire intr_cfg_pkg::cpu_mask_t mask_in, // processor mask now in force
    input wire logic [intr_cfg_pkg::NSRC-intr_cfg_pkg::NEXT-1:0] periph_req_in, // other sources
    output logic [intr_cfg_pkg::NEXT-1:0] ext_req_out, // enabled pending requests
    output logic nmi_req_out, // one-cycle nonmaskable request
    output intr_cfg_pkg::int_req_t int_out, // request presented to the processor
    output logic [2:0] xfer_level_out, // transfer controller level
    output logic [2:0] cpu_level_out, // processor level
    output logic cpu_wins_out // processor outranks the transfer controller
);

    intr_cfg_pkg::state_t s; // registered state
    intr_cfg_pkg::state_t n; // next state

    logic hit; // request on the bus
    logic wr; // write takes effect at this edge
    logic rd_take; // read data taken at this edge
    logic [15:0] lane_m; // byte lane mask for the low half word
    logic [15:0] img; // merged register image
    logic [3:0] preg; // priority register index
    logic is_prio; // address falls in the priority window
    logic [intr_cfg_pkg::NEXT-1:0] det; // detection events this cycle
    logic [intr_cfg_pkg::NEXT-1:0] chg; // sense field changed this cycle
    logic [intr_cfg_pkg::NEXT-1:0] clr; // software clears this cycle
    logic [intr_cfg_pkg::NSRC-1:0] req; // all requests entering arbitration
    logic found; // some request is present
    logic [2:0] best_lvl; // highest level seen
    logic [5:0] best_src; // source holding it

    // detection for one input from its sense code and filtered level
    function automatic logic sense_hit(input logic [1:0] code, input logic old_l,
                                       input logic new_l);
        logic r;
        r = 1'b0;
        unique case (code)
            `SENSE_LOW: r = !new_l;
            `SENSE_FALL: r = old_l & !new_l;
            `SENSE_RISE: r = !old_l & new_l;
            `SENSE_BOTH: r = old_l ^ new_l;
        endcase
        return r;
    endfunction

    // thirteen-input vector as laid out in enable and pending registers
    function automatic logic [15:0] pack13(input logic [12:0] v);
        return {1'b0, v[12], 2'h0, v[11:0]};
    endfunction

    // inverse of pack13; reserved positions are dropped
    function automatic logic [12:0] unpack13(input logic [15:0] d);
        return {d[`VD_ENABLE_BIT], d[11:0]};
    endfunction

    // byte lane merge of a half word write
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [15:0] m);
        return (old_v & ~m) | (new_v & m);
    endfunction

    // image of one priority register; reserved bits read zero
    function automatic logic [15:0] prio_image(input logic [intr_cfg_pkg::NSRC-1:0][2:0] p,
                                               input logic [3:0] r);
        return {1'b0, p[{r, 2'h3}], 1'b0, p[{r, 2'h2}],
                1'b0, p[{r, 2'h1}], 1'b0, p[{r, 2'h0}]};
    endfunction

    // next state: bus slave, sensing, pending flags and arbitration
    always_comb begin
        n = s;
        hit = wb_in.cyc & wb_in.stb;
        // ack rises one cycle after the request; writes land on the ack edge
        n.ack = hit & !s.ack;
        wr = hit & wb_in.we & s.ack;
        rd_take = hit & !wb_in.we & s.ack;
        lane_m = {{8{wb_in.sel[1]}}, {8{wb_in.sel[0]}}};
        is_prio = (wb_in.adr & `ADR_PRIO_MASK) == `ADR_PRIO_BASE;
        preg = wb_in.adr[5:2];
        img = 16'h0000;

        // three-stage sampling; a change counts once stages two and three agree
        n.sync1 = {nmi_pin_in, volt_detect_b_in, irq_pin_b_in};
        n.sync2 = s.sync1;
        n.sync3 = s.sync2;
        for (int i = 0; i < intr_cfg_pkg::NSYNC; i++) begin
            n.filt[i] = (s.sync2[i] == s.sync3[i]) ? s.sync3[i] : s.filt[i];
        end

        // nonmaskable request on the selected edge
        n.nmi_req = s.nmi_edge ? (!s.filt[13] & n.filt[13])
                               : (s.filt[13] & !n.filt[13]);

        // per-input detection from the sense code
        for (int i = 0; i < intr_cfg_pkg::NEXT; i++) begin
            det[i] = sense_hit(s.sense[i], s.filt[i], n.filt[i]);
        end

        // mode register: only mode and edge bits are writable
        if (wr && wb_in.adr == `ADR_MODE && wb_in.sel[0]) begin
            n.mode = wb_in.dat[`MODE_SEL_LSB +: 2];
            n.nmi_edge = wb_in.dat[`NMI_EDGE_BIT];
        end

        // processor priority register
        if (wr && wb_in.adr == `ADR_CPUPRI && wb_in.sel[0]) begin
            n.cpu_pce = wb_in.dat[`CPU_PCE_BIT];
            n.xfer_pri = wb_in.dat[`XFER_PRI_LSB +: 3];
            n.auto_pri = wb_in.dat[`AUTO_PRI_BIT];
            // while tracking is on the field belongs to hardware
            if (!s.auto_pri) begin
                n.cpu_pri = wb_in.dat[`CPU_PRI_LSB +: 3];
            end
        end
        // tracking copies the mask now in force; the single flag zero-extends
        if (s.auto_pri) begin
            n.cpu_pri = (s.mode == `MODE_TWO) ? mask_in.three_bit_interrupt_mask
                                              : {2'h0, mask_in.single_mask_flag};
        end

        // enable register; reserved bits are not stored
        if (wr && wb_in.adr == `ADR_ENABLE) begin
            img = merge16(pack13(s.enable), wb_in.dat[15:0], lane_m);
            n.enable = unpack13(img);
        end

        // sense registers: high holds input 14 and 11..8, low holds 7..0
        if (wr && wb_in.adr == `ADR_SENSE_HI) begin
            img = merge16({2'h0, s.sense[12], 4'h0, s.sense[11:8]},
                          wb_in.dat[15:0], lane_m);
            n.sense[12] = img[`VD_SENSE_LSB +: 2];
            n.sense[11:8] = img[7:0];
        end
        if (wr && wb_in.adr == `ADR_SENSE_LO) begin
            img = merge16(s.sense[7:0], wb_in.dat[15:0], lane_m);
            n.sense[7:0] = img;
        end
        // a sense change is treated as an event, as the real sampler would see
        for (int i = 0; i < intr_cfg_pkg::NEXT; i++) begin
            chg[i] = n.sense[i] != s.sense[i];
        end

        // pending flags: written zero after read as one clears, set wins
        clr = '0;
        if (wr && wb_in.adr == `ADR_PENDING) begin
            clr = s.seen & ~unpack13(wb_in.dat[15:0]) & unpack13(lane_m);
            n.seen = s.seen & ~unpack13(lane_m);
        end
        if (rd_take && wb_in.adr == `ADR_PENDING) begin
            n.seen = s.seen | (s.pending & unpack13(lane_m));
        end
        n.pending = (s.pending & ~clr) | det | chg;
        n.ext_req = n.pending & n.enable;

        // priority registers; the field at bits 14..12 is the highest source
        if (wr && is_prio) begin
            img = merge16(prio_image(s.prio, preg), wb_in.dat[15:0], lane_m);
            n.prio[{preg, 2'h3}] = img[14:12];
            n.prio[{preg, 2'h2}] = img[10:8];
            n.prio[{preg, 2'h1}] = img[6:4];
            n.prio[{preg, 2'h0}] = img[2:0];
        end

        // read data is captured as ack rises; unmapped reads return zero
        if (hit && !wb_in.we && !s.ack) begin
            n.rdata = 32'h0000_0000;
            if (is_prio) begin
                n.rdata[15:0] = prio_image(s.prio, preg);
            end else begin
                unique case (wb_in.adr)
                    `ADR_MODE: begin
                        n.rdata[`MODE_SEL_LSB +: 2] = s.mode;
                        n.rdata[`NMI_EDGE_BIT] = s.nmi_edge;
                    end
                    `ADR_CPUPRI: begin
                        n.rdata[7:0] = {s.cpu_pce, s.xfer_pri, s.auto_pri, s.cpu_pri};
                    end
                    `ADR_ENABLE: n.rdata[15:0] = pack13(s.enable);
                    `ADR_SENSE_HI: n.rdata[15:0] = {2'h0, s.sense[12], 4'h0, s.sense[11:8]};
                    `ADR_SENSE_LO: n.rdata[15:0] = s.sense[7:0];
                    `ADR_PENDING: n.rdata[15:0] = pack13(s.pending);
                    default: n.rdata = 32'h0000_0000; // unmapped address
                endcase
            end
        end

        // arbitration: highest level wins, lower source index breaks ties
        req = {periph_req_in, s.ext_req};
        found = 1'b0;
        best_lvl = 3'h0;
        best_src = 6'h00;
        for (int k = intr_cfg_pkg::NSRC - 1; k >= 0; k--) begin
            if (req[k] && (!found || s.prio[k] >= best_lvl)) begin
                found = 1'b1;
                best_lvl = s.prio[k];
                best_src = 6'(k);
            end
        end
        // gating depends on mode; the prohibited codes present nothing
        unique case (s.mode)
            `MODE_ZERO: n.intr.req = found & !mask_in.single_mask_flag;
            `MODE_TWO: n.intr.req = found &
                (best_lvl > mask_in.three_bit_interrupt_mask);
            default: n.intr.req = 1'b0;
        endcase
        n.intr.src = best_src;
        n.intr.lvl = best_lvl;

        // processor against transfer controller; ties go to the controller
        n.cpu_wins = s.cpu_pce & (s.cpu_pri > s.xfer_pri);
    end

    // state register; reset priority fields to level seven, sampler stages and filter to one, the rest to zero
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s <= '0;
            s.prio <= {intr_cfg_pkg::NSRC{`PRIO_RESET}};
            s.sync1 <= '1;
            s.sync2 <= '1;
            s.sync3 <= '1;
            s.filt <= '1;
        end else if (ce_in) begin
            s <= n;
        end
    end

    // outputs straight from flip-flops
    assign wb_out.ack = s.ack;
    assign wb_out.dat = s.rdata;
    assign ext_req_out = s.ext_req;
    assign nmi_req_out = s.nmi_req;
    assign int_out = s.intr;
    assign xfer_level_out = s.xfer_pri;
    assign cpu_level_out = s.cpu_pri;
    assign cpu_wins_out = s.cpu_wins;

    // a read of the mode register shows only mode and edge
    property p_mode_reserved;
        @(posedge clk_in) disable iff (!rst_b_in)
        (ce_in && wb_in.cyc && wb_in.stb && !wb_in.we && !s.ack && wb_in.adr == `ADR_MODE)
        |=> (wb_out.dat[7:6] == 2'h0 && wb_out.dat[2:0] == 3'h0);
    endproperty
    a_mode_reserved: assert property (p_mode_reserved)
        else $error("mode register reserved bits not zero");

    // priority register reserved bits read zero
    property p_prio_reserved;
        @(posedge clk_in) disable iff (!rst_b_in)
        (ce_in && wb_in.cyc && wb_in.stb && !wb_in.we && !s.ack && is_prio)
        |=> (wb_out.dat[15] == 1'b0 && wb_out.dat[11] == 1'b0 &&
             wb_out.dat[7] == 1'b0 && wb_out.dat[3] == 1'b0);
    endproperty
    a_prio_reserved: assert property (p_prio_reserved)
        else $error("priority register reserved bit set");

    // tracking in mode 2 copies the three-bit mask
    property p_auto_track;
        @(posedge clk_in) disable iff (!rst_b_in)
        (ce_in && s.auto_pri && s.mode == `MODE_TWO)
        |=> (cpu_level_out == $past(mask_in.three_bit_interrupt_mask));
    endproperty
    a_auto_track: assert property (p_auto_track)
        else $error("processor level does not follow the mask");

    // without tracking and without a write the level stands
    property p_cpu_hold;
        @(posedge clk_in) disable iff (!rst_b_in)
        (ce_in && !s.auto_pri && !(wr && wb_in.adr == `ADR_CPUPRI))
        |=> $stable(cpu_level_out);
    endproperty
    a_cpu_hold: assert property (p_cpu_hold)
        else $error("processor level changed without a write");

    // mode 2 presents only levels above the mask
    property p_mode2_gate;
        @(posedge clk_in) disable iff (!rst_b_in)
        (ce_in && s.mode == `MODE_TWO)
        |=> (!int_out.req || int_out.lvl > $past(mask_in.three_bit_interrupt_mask));
    endproperty
    a_mode2_gate: assert property (p_mode2_gate)
        else $error("request presented at or below the mask");

    // mode 0 with the flag set presents nothing
    property p_mode0_gate;
        @(posedge clk_in) disable iff (!rst_b_in)
        (ce_in && s.mode == `MODE_ZERO && mask_in.single_mask_flag) |=> !int_out.req;
    endproperty
    a_mode0_gate: assert property (p_mode0_gate)
        else $error("request presented while the flag masks");

    // falling edge selected: a filtered fall raises the request
    property p_nmi_fall;
        @(posedge clk_in) disable iff (!rst_b_in)
        (ce_in && !s.nmi_edge && s.filt[13] && !n.filt[13]) |=> nmi_req_out;
    endproperty
    a_nmi_fall: assert property (p_nmi_fall)
        else $error("nonmaskable fall missed");

    // processor priority off means processor never wins
    property p_cpu_lowest;
        @(posedge clk_in) disable iff (!rst_b_in)
        (ce_in && !s.cpu_pce) |=> !cpu_wins_out;
    endproperty
    a_cpu_lowest: assert property (p_cpu_lowest)
        else $error("processor won with priority control off");

    // sense change of input 0 sets its pending flag
    property p_sense_change;
        @(posedge clk_in) disable iff (!rst_b_in)
        (ce_in && wr && wb_in.adr == `ADR_SENSE_LO && wb_in.sel[0] &&
         wb_in.dat[1:0] != s.sense[0]) |=> s.pending[0];
    endproperty
    a_sense_change: assert property (p_sense_change)
        else $error("sense change left pending flag clear");

    // read-one then write-zero clears flag 0 when no new event comes
    sequence s_read_one;
        ce_in && rd_take && wb_in.adr == `ADR_PENDING && wb_in.sel[0] && s.pending[0];
    endsequence
    sequence s_write_zero;
        ce_in && wr && wb_in.adr == `ADR_PENDING && wb_in.sel[0] && !wb_in.dat[0] &&
        !det[0] && !chg[0];
    endsequence
    property p_clear_flag;
        @(posedge clk_in) disable iff (!rst_b_in)
        s_read_one ##[2:20] s_write_zero |=> !s.pending[0];
    endproperty
    a_clear_flag: assert property (p_clear_flag)
        else $error("pending flag not cleared by write of zero");

endmodule

`default_nettype wire

// ==== core_model.sv ====
// processor and pin side model for the interrupt configuration block
// assumes one clock shared with the block; the bench commands levels
`timescale 1ns/100ps
`default_nettype none

module core_model (
    input wire logic clk_in, // system clock
    input wire logic rst_b_in, // reset, active low
    input wire logic [11:0] pins_cmd_in, // wanted pin levels
    input wire logic nmi_cmd_in, // wanted nonmaskable pin level
    input wire intr_cfg_pkg::cpu_mask_t mask_cmd_in, // wanted processor mask
    input wire logic nmi_req_in, // nonmaskable pulse from the block
    output logic [11:0] irq_pin_b_out, // external request pins
    output logic nmi_pin_out, // nonmaskable pin
    output logic volt_detect_b_out, // voltage detector line
    output intr_cfg_pkg::cpu_mask_t mask_out, // mask now in force
    output logic [50:0] periph_req_out, // other sources, kept quiet
    output logic [7:0] nmi_count_out // nonmaskable pulses seen
);
    // pins idle high as with pull-ups; the mask moves on a clock edge
    // like a core register, so the block never sees it mid-cycle
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_pin_b_out <= 12'hFFF;
            nmi_pin_out <= 1'h1;
            mask_out <= '0;
            nmi_count_out <= 8'h00;
        end else begin
            irq_pin_b_out <= pins_cmd_in;
            nmi_pin_out <= nmi_cmd_in;
            mask_out <= mask_cmd_in;
            nmi_count_out <= nmi_count_out + {7'h00, nmi_req_in};
        end
    end

    // detector held inactive: only a falling edge would be legal here
    assign volt_detect_b_out = 1'h1;
    assign periph_req_out = '0;
endmodule

`default_nettype wire

// ==== intr_cfg_test.sv ====
// self-checking bench for the interrupt configuration block
// assumes the wishbone slave acks one cycle after a request
`timescale 1ns/100ps
`default_nettype none
`include "intr_cfg_regs.svh"

module intr_cfg_test;
    logic clk_in = 1'h0; // 100 MHz clock
    logic rst_b_in = 1'h0; // reset, active low
    logic ce = 1'h1; // clock enable, lowered once to freeze the block
    intr_cfg_pkg::wb_req_t wb_req = '0; // bus request
    intr_cfg_pkg::wb_rsp_t wb_rsp; // bus answer
    logic [11:0] pins_cmd = 12'hFFF; // pin levels wanted
    logic nmi_cmd = 1'h1; // nonmaskable level wanted
    intr_cfg_pkg::cpu_mask_t mask_cmd = '0; // mask wanted
    intr_cfg_pkg::cpu_mask_t mask; // mask driven
    intr_cfg_pkg::int_req_t int_req; // request to processor
    logic [11:0] pins; // pins driven
    logic nmi_pin, vd_b, nmi_req, cpu_wins;
    logic [50:0] periph;
    logic [12:0] ext_req;
    logic [2:0] xfer_lvl, cpu_lvl;
    logic [7:0] nmi_count;
    logic [31:0] rdat;
    int failures = 0;
    int compares = 0;
    int cycles = 0;

    always #5 clk_in = ~clk_in;

    intr_cfg intr_cfg_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce),
        .wb_in(wb_req), .wb_out(wb_rsp), .irq_pin_b_in(pins), .nmi_pin_in(nmi_pin),
        .volt_detect_b_in(vd_b), .mask_in(mask), .periph_req_in(periph),
        .ext_req_out(ext_req), .nmi_req_out(nmi_req), .int_out(int_req),
        .xfer_level_out(xfer_lvl), .cpu_level_out(cpu_lvl), .cpu_wins_out(cpu_wins));

    core_model core_model_inst (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .pins_cmd_in(pins_cmd), .nmi_cmd_in(nmi_cmd), .mask_cmd_in(mask_cmd),
        .nmi_req_in(nmi_req), .irq_pin_b_out(pins), .nmi_pin_out(nmi_pin),
        .volt_detect_b_out(vd_b), .mask_out(mask), .periph_req_out(periph),
        .nmi_count_out(nmi_count));

    // compare and count; an unknown never matches
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("counts: %0d compares, %0d failures", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // one classic cycle, entered just after a rising edge; the wait for
    // ack is unbounded here because the cycle counter below cuts hangs
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        wb_req <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: adr, dat: dat, sel: 4'hF};
        do @(posedge clk_in); while (wb_rsp.ack !== 1'h1);
        rdat = wb_rsp.dat;
        wb_req <= '0;
        @(posedge clk_in);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        xfer(1'h1, adr, dat);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        xfer(1'h0, adr, 32'h0);
        check(rdat, exp);
    endtask

    // outputs lag inputs by the mask register plus one cycle of logic
    task automatic settle();
        repeat (3) @(posedge clk_in);
    endtask

    // hang guard, far above the fewer than two hundred cycles the tests need
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (8) @(posedge clk_in);
        rst_b_in <= 1'h1;
        @(posedge clk_in);
        rd_chk(`ADR_MODE, 32'h0);
        rd_chk(`ADR_CPUPRI, 32'h0);
        rd_chk(`ADR_PRIO_BASE, 32'h7777);
        rd_chk(`ADR_ENABLE, 32'h0);
        rd_chk(8'h20, 32'h0);
        $display("test reset values done");
        // reserved bits written one, mode kept to a legal code
        wr(`ADR_MODE, 32'hEF);
        rd_chk(`ADR_MODE, 32'h28);
        wr(`ADR_PRIO_BASE + 8'h04, 32'hFFFF);
        rd_chk(`ADR_PRIO_BASE + 8'h04, 32'h7777);
        wr(`ADR_PRIO_BASE + 8'h04, 32'h0531);
        rd_chk(`ADR_PRIO_BASE + 8'h04, 32'h0531);
        wr(`ADR_ENABLE, 32'h4FFF);
        rd_chk(`ADR_ENABLE, 32'h4FFF);
        wr(`ADR_ENABLE, 32'h0);
        $display("test access kinds done");
        // mode 2 with auto copy: software level write must be lost
        wr(`ADR_MODE, 32'h20);
        mask_cmd <= '{single_mask_flag: 1'h0, three_bit_interrupt_mask: 3'h5};
        settle();
        wr(`ADR_CPUPRI, 32'h0B);
        settle();
        rd_chk(`ADR_CPUPRI, 32'h0D);
        wr(`ADR_CPUPRI, 32'h0E);
        rd_chk(`ADR_CPUPRI, 32'h0D);
        // this write still meets tracking on, so the level keeps mask 5
        wr(`ADR_CPUPRI, 32'hA3);
        mask_cmd <= '{single_mask_flag: 1'h0, three_bit_interrupt_mask: 3'h6};
        settle();
        rd_chk(`ADR_CPUPRI, 32'hA5);
        check({29'h0, xfer_lvl}, 32'h2);
        check({29'h0, cpu_lvl}, 32'h5);
        check({31'h0, cpu_wins}, 32'h1);
        wr(`ADR_CPUPRI, 32'h23);
        settle();
        check({29'h0, cpu_lvl}, 32'h3);
        check({31'h0, cpu_wins}, 32'h0);
        $display("test processor priority done");
        // sense change with request off, then clear before enabling
        wr(`ADR_MODE, 32'h0);
        mask_cmd <= '0;
        wr(`ADR_SENSE_LO, 32'h1);
        rd_chk(`ADR_PENDING, 32'h1);
        wr(`ADR_PENDING, 32'h0);
        rd_chk(`ADR_PENDING, 32'h0);
        wr(`ADR_ENABLE, 32'h1);
        settle();
        check({31'h0, int_req.req}, 32'h0);
        pins_cmd <= 12'hFFE;
        for (int i = 0; i < 20 && ext_req[0] !== 1'h1; i++) @(posedge clk_in);
        check({19'h0, ext_req}, 32'h1);
        settle();
        check({22'h0, int_req}, {22'h0, 1'h1, 6'h0, 3'h7});
        mask_cmd <= '{single_mask_flag: 1'h1, three_bit_interrupt_mask: 3'h0};
        settle();
        check({31'h0, int_req.req}, 32'h0);
        wr(`ADR_MODE, 32'h20);
        mask_cmd <= '{single_mask_flag: 1'h1, three_bit_interrupt_mask: 3'h6};
        settle();
        check({31'h0, int_req.req}, 32'h1);
        mask_cmd <= '{single_mask_flag: 1'h0, three_bit_interrupt_mask: 3'h7};
        settle();
        check({31'h0, int_req.req}, 32'h0);
        $display("test pin request done");
        // nonmaskable edge: falling first, then rising only
        nmi_cmd <= 1'h0;
        repeat (8) @(posedge clk_in);
        check({24'h0, nmi_count}, 32'h1);
        wr(`ADR_MODE, 32'h08);
        nmi_cmd <= 1'h1;
        repeat (8) @(posedge clk_in);
        nmi_cmd <= 1'h0;
        repeat (8) @(posedge clk_in);
        check({24'h0, nmi_count}, 32'h2);
        $display("test nonmaskable edge done");
        // enable low freezes the sampler: the rising edge waits for it
        ce <= 1'h0;
        nmi_cmd <= 1'h1;
        repeat (8) @(posedge clk_in);
        check({24'h0, nmi_count}, 32'h2);
        ce <= 1'h1;
        repeat (8) @(posedge clk_in);
        check({24'h0, nmi_count}, 32'h3);
        $display("test clock enable done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
